/* File: hdl/otp_array.sv */
// fuse array: main sectors plus spare rows, and the stored security word
// assumes the controller never reads and writes the same row in one cycle
module otp_array (
  // clock
  input wire logic clk,
  // read port, data one cycle after the enable
  input wire logic rdEn,
  input wire logic [otp_pkg::ROW_W-1:0] rdAddr,
  output logic [otp_pkg::WORD_W-1:0] rdData,
  // programming port
  input wire logic wrEn,
  input wire logic [otp_pkg::ROW_W-1:0] wrAddr,
  input wire logic [otp_pkg::WORD_W-1:0] wrData,
  input wire logic secWr,
  input wire logic [otp_pkg::WORD_W-1:0] secWdata,
  output logic [otp_pkg::WORD_W-1:0] secWord
);
  import otp_pkg::*;

  // fuses hold their contents through reset; they start erased at power-on only
  logic [WORD_W-1:0] mem [TOTAL_ROWS] = '{default: ERASED_WORD};
  logic [WORD_W-1:0] secStore_r = ERASED_WORD;

  assign secWord = secStore_r;

  // programming only ever sets bits, so an erased bit can blow but never heal
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= mem[wrAddr] | wrData; // [R18]
    end
  end

  always_ff @(posedge clk) begin
    if (secWr) begin
      secStore_r <= secStore_r | secWdata; // [R18]
    end
  end

  // synchronous read
  always_ff @(posedge clk) begin
    if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule

/* File: hdl/otp_boot_seq.sv */
// power-up sequencer: fetch the security word, then copy the main rows into SRAM
// assumes the array read port is its own until done rises
module otp_boot_seq (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // array read port
  output logic arrRdEn,
  output logic [otp_pkg::ROW_W-1:0] arrRdAddr,
  input wire logic [otp_pkg::WORD_W-1:0] arrRdData,
  // security load pulse and completion
  output logic secLoad,
  output logic done,
  // SRAM write port
  output logic sramWr,
  output logic [otp_pkg::SRAM_AW-1:0] sramAddr,
  output logic [otp_pkg::WORD_W-1:0] sramWdata
);
  import otp_pkg::*;

  typedef enum logic [1:0] {S_SEC, S_COPY, S_DRAIN, S_DONE} boot_e;

  boot_e state_r;
  logic [SRAM_AW-1:0] row_r;
  logic rdValid_r;
  logic [SRAM_AW-1:0] rdRow_r;

  // one row read per cycle; the write trails its read by two cycles
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= S_SEC;
      row_r <= '0;
    end else begin
      unique case (state_r)
        S_SEC: state_r <= S_COPY; // [R2]
        S_COPY: begin
          row_r <= row_r + 1'b1;
          if (row_r == SRAM_AW'(MAIN_ROWS - 1)) begin
            state_r <= S_DRAIN;
          end
        end
        S_DRAIN: state_r <= S_DONE;
        S_DONE: state_r <= S_DONE;
      endcase
    end
  end

  assign arrRdEn = (state_r == S_COPY);
  assign arrRdAddr = ROW_W'(row_r);

  // security word comes first so the locks hold before anything else runs
  always_ff @(posedge clk) begin
    if (srst) begin
      secLoad <= 1'b0;
      done <= 1'b0;
    end else begin
      secLoad <= (state_r == S_SEC); // [R2]
      done <= (state_r == S_DONE);
    end
  end

  // copy stage into SRAM
  always_ff @(posedge clk) begin
    if (srst) begin
      rdValid_r <= 1'b0;
      rdRow_r <= '0;
      sramWr <= 1'b0;
      sramAddr <= '0;
      sramWdata <= '0;
    end else begin
      rdValid_r <= arrRdEn;
      rdRow_r <= row_r;
      sramWr <= rdValid_r; // [R3]
      sramAddr <= rdRow_r;
      sramWdata <= arrRdData;
    end
  end

endmodule

/* File: hdl/otp_pkg.sv */
// shared constants for the one-time-programmable memory controller and its security word
// assumes a single 200 MHz tile clock and a synchronous active-high reset
package otp_pkg;

  // array geometry
  localparam int WORD_W = 32;
  localparam int SECTORS = 4;
  localparam int SECTOR_ROWS = 512;
  localparam int SECTOR_AW = 9;
  localparam int SPARE_ROWS = 16;
  localparam int MAIN_ROWS = SECTORS * SECTOR_ROWS;
  localparam int TOTAL_ROWS = MAIN_ROWS + SPARE_ROWS;
  localparam int ROW_W = 12;
  localparam int SRAM_AW = 11;
  localparam int PORT16_W = 16;

  // register bus: the three programming ports sit at their resource identifiers
  localparam int REG_AW = 24;
  localparam logic [REG_AW-1:0] SEC_OFS = 24'h000000;
  localparam logic [REG_AW-1:0] ADDR_PORT_OFS = 24'h100200;
  localparam logic [REG_AW-1:0] DATA_PORT_OFS = 24'h200100;
  localparam logic [REG_AW-1:0] CTRL_PORT_OFS = 24'h100300;

  // security word bit positions
  localparam int SEC_JTAG_OFF = 0;
  localparam int SEC_LINK_OFF = 1;
  localparam int SEC_BOOT_OTP = 5;
  localparam int SEC_REDUND = 7;
  localparam int SEC_LOCK0 = 8;
  localparam int SEC_MASTER = 12;
  localparam int SEC_JTAG_OTP = 13;
  localparam int SEC_GP_LO = 15;
  localparam int SEC_GP_HI = 21;
  localparam int SEC_UID_LO = 22;
  localparam int SEC_UID_HI = 31;
  localparam int UID_W = SEC_UID_HI - SEC_UID_LO + 1;
  localparam logic [WORD_W-1:0] SEC_RESET = 32'h00000000;
  localparam logic [WORD_W-1:0] ERASED_WORD = 32'h00000000;

  // control port: command in the low bits, error clear on top
  localparam int CMD_W = 2;
  localparam logic [CMD_W-1:0] CMD_READ = 2'h1;
  localparam logic [CMD_W-1:0] CMD_PROG = 2'h2;
  localparam logic [CMD_W-1:0] CMD_PROG_SEC = 2'h3;
  localparam int CTRL_CLR_ERR = 15;

  // status bits returned by a control port read
  localparam int ST_DONE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_ERR = 2;
  localparam int ST_RDV = 3;

  // programming pulse: a least time, rounded up to whole cycles
  localparam int PROG_TIME_NS = 1000;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PROG_CYCLES = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PROG_CNT_W = 8;

  // whether a row may be read or programmed, given the security word
  function automatic logic rowInRange(input logic [WORD_W-1:0] sec, input logic [PORT16_W-1:0] row);
    rowInRange = (row < PORT16_W'(MAIN_ROWS)) || (sec[SEC_REDUND] && (row < PORT16_W'(TOTAL_ROWS)));
  endfunction

  function automatic logic progAllowed(input logic [WORD_W-1:0] sec, input logic [PORT16_W-1:0] row,
                                       input logic toSec);
    logic [1:0] sector;
    sector = row[SECTOR_AW +: 2];
    if (sec[SEC_MASTER]) begin
      progAllowed = 1'b0;
    end else if (toSec) begin
      progAllowed = 1'b1;
    end else if (!rowInRange(sec, row)) begin
      progAllowed = 1'b0;
    end else if (row < PORT16_W'(MAIN_ROWS)) begin
      progAllowed = !sec[SEC_LOCK0 + int'(sector)];
    end else begin
      progAllowed = 1'b1;
    end
  endfunction

endpackage

/* File: hdl/otp_security_config.sv */
// OTP controller top: security register, programming ports, access gating
// assumes the register bus and debug requests run on clk; srst acts as power-up
// no interrupt logic: software polls the status word behind the control port
//
// Behaviour
// [R1] four lockable sectors of 512 32-bit rows
// [R2] security word loaded before processor runs
// [R3] remaining contents copied to SRAM first
// [R4] row address on 16-bit port 0x100200
// [R5] program data on 32-bit port 0x200100
// [R6] control commands on 16-bit port 0x100300
// [R7] bit 0 blocks all JTAG access
// [R8] bit 1 blocks switch access from tiles
// [R9] bit 5 boots from OTP, bypasses ROM
// [R10] bit 7 enables spare redundant rows
// [R11] bits 8-11 lock sectors 0-3
// [R12] bit 12 blocks all programming
// [R13] bit 13 blocks JTAG access to OTP
// [R14] bits 21:15 software-readable general storage
// [R15] bits 31:22 extend JTAG user code
// [R16] unprogrammed user code reads all zeros
// [R17] locked programming leaves array unchanged
// [R18] programming only sets bits, never clears
module otp_security_config (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register bus
  input wire logic [otp_pkg::REG_AW-1:0] regAddr,
  input wire logic [otp_pkg::WORD_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [otp_pkg::WORD_W-1:0] regRdata,
  // access requests and grants
  input wire logic jtagReq,
  input wire logic linkReq,
  input wire logic jtagOtpReq,
  output logic jtagGrant,
  output logic linkGrant,
  output logic jtagOtpGrant,
  // boot configuration to the processor
  output logic cpuRun,
  output logic bootRomBypass,
  output logic redundantEn,
  output logic [otp_pkg::UID_W-1:0] userIdCode,
  // SRAM write port used by the power-up copy
  output logic sramWr,
  output logic [otp_pkg::SRAM_AW-1:0] sramAddr,
  output logic [otp_pkg::WORD_W-1:0] sramWdata
);
  import otp_pkg::*;

  // C_CAP gives the array word one cycle to settle before it is captured
  typedef enum logic [1:0] {C_IDLE, C_READ, C_CAP, C_PROG} cmd_e;

  cmd_e cmdState_r;
  logic [WORD_W-1:0] secReg_r;
  logic [PORT16_W-1:0] addrPort_r;
  logic [WORD_W-1:0] dataPort_r;
  logic [WORD_W-1:0] rdWord_r;
  logic rdValid_r;
  logic err_r;
  logic errSet;
  logic progSec_r;
  logic [PROG_CNT_W-1:0] progCnt_r;
  logic arrWr_r;
  logic arrSecWr_r;
  logic rdOk_r;
  // boot sequencer and array wiring
  logic bootDone;
  logic secLoad;
  logic bootRdEn;
  logic [ROW_W-1:0] bootRdAddr;
  logic arrRdEn;
  logic [ROW_W-1:0] arrRdAddr;
  logic [WORD_W-1:0] arrRdData;
  logic [WORD_W-1:0] secWord;
  logic ctrlWr;
  logic [CMD_W-1:0] cmd;
  logic [WORD_W-1:0] status;
  logic [ROW_W-1:0] opRow_r;
  logic [WORD_W-1:0] opData_r;
  logic cmdTake;

  // array: 4 x 512 rows plus spares, sector taken from row bits 10:9
  // the fuse ports see only the latched command values, never the live software ports
  otp_array u_array ( // [R1]
    .clk(clk),
    .rdEn(arrRdEn),
    .rdAddr(arrRdAddr),
    .rdData(arrRdData),
    .wrEn(arrWr_r),
    .wrAddr(opRow_r),
    .wrData(opData_r),
    .secWr(arrSecWr_r),
    .secWdata(opData_r),
    .secWord(secWord)
  );

  otp_boot_seq u_boot (
    .clk(clk),
    .srst(srst),
    .arrRdEn(bootRdEn),
    .arrRdAddr(bootRdAddr),
    .arrRdData(arrRdData),
    .secLoad(secLoad),
    .done(bootDone),
    .sramWr(sramWr),
    .sramAddr(sramAddr),
    .sramWdata(sramWdata)
  );

  // the boot copy owns the read port until it finishes; commands before then are dropped
  assign arrRdEn = bootRdEn | (cmdState_r == C_READ);
  assign arrRdAddr = bootRdEn ? bootRdAddr : opRow_r;

  // register bus decode
  assign ctrlWr = regWr && (regAddr == CTRL_PORT_OFS); // [R6]
  assign cmd = regWdata[CMD_W-1:0];
  // a command is taken only when idle and the boot copy is over; anything else is dropped silently
  assign cmdTake = ctrlWr && bootDone && (cmdState_r == C_IDLE);

  // programming ports, written by software
  always_ff @(posedge clk) begin
    if (srst) begin
      addrPort_r <= '0;
      dataPort_r <= '0;
    end else begin
      if (regWr && (regAddr == ADDR_PORT_OFS)) begin
        addrPort_r <= regWdata[PORT16_W-1:0]; // [R4]
      end
      if (regWr && (regAddr == DATA_PORT_OFS)) begin
        dataPort_r <= regWdata; // [R5]
      end
    end
  end

  // row and word are latched when a command is taken, so a port write while busy
  // cannot redirect a fuse pulse already under way; costs one row and one word of flops
  // and keeps the read address steady for the whole read too
  always_ff @(posedge clk) begin
    if (srst) begin
      opRow_r <= '0;
      opData_r <= '0;
    end else if (cmdTake) begin
      opRow_r <= addrPort_r[ROW_W-1:0];
      opData_r <= dataPort_r;
    end
  end

  // command sequencer; a command while busy or before boot ends is dropped
  // an out-of-range read still walks C_READ and C_CAP, so every read takes the same time
  always_ff @(posedge clk) begin
    if (srst) begin
      cmdState_r <= C_IDLE;
      progSec_r <= 1'b0;
      progCnt_r <= '0;
      rdOk_r <= 1'b0;
    end else begin
      unique case (cmdState_r)
        C_IDLE: begin
          if (cmdTake) begin
            if (cmd == CMD_READ) begin
              cmdState_r <= C_READ;
              rdOk_r <= rowInRange(secReg_r, addrPort_r); // [R10]
            end else if ((cmd == CMD_PROG) || (cmd == CMD_PROG_SEC)) begin
              if (progAllowed(secReg_r, addrPort_r, cmd == CMD_PROG_SEC)) begin
                cmdState_r <= C_PROG; // [R11] [R12]
                progSec_r <= (cmd == CMD_PROG_SEC);
                progCnt_r <= PROG_CNT_W'(PROG_CYCLES - 1);
              end
            end
          end
        end
        C_READ: cmdState_r <= C_CAP;
        C_CAP: cmdState_r <= C_IDLE;
        C_PROG: begin
          // the counter spans the least pulse time, rounded up to whole cycles
          if (progCnt_r == '0) begin
            cmdState_r <= C_IDLE;
          end else begin
            progCnt_r <= progCnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  // the fuse write fires once at the end of the pulse; refused requests never get here
  // a reset in mid-pulse clears the state first, so no row is ever half written
  always_ff @(posedge clk) begin
    if (srst) begin
      arrWr_r <= 1'b0;
      arrSecWr_r <= 1'b0;
    end else begin
      arrWr_r <= (cmdState_r == C_PROG) && (progCnt_r == '0) && !progSec_r; // [R17]
      arrSecWr_r <= (cmdState_r == C_PROG) && (progCnt_r == '0) && progSec_r; // [R12]
    end
  end

  // read result; an out-of-range row returns the erased value
  always_ff @(posedge clk) begin
    if (srst) begin
      rdWord_r <= '0;
      rdValid_r <= 1'b0;
    end else if (cmdState_r == C_CAP) begin
      rdWord_r <= rdOk_r ? arrRdData : ERASED_WORD;
      rdValid_r <= rdOk_r;
    end else if (cmdTake && (cmd == CMD_READ)) begin
      rdValid_r <= 1'b0;
    end
  end

  // sticky refusal flag; a new refusal beats a clear in the same cycle
  // software clears it with bit 15 of a control write; commands never clear it
  assign errSet = cmdTake &&
                  ((((cmd == CMD_PROG) || (cmd == CMD_PROG_SEC)) &&
                    !progAllowed(secReg_r, addrPort_r, cmd == CMD_PROG_SEC)) ||
                   ((cmd == CMD_READ) && !rowInRange(secReg_r, addrPort_r)));

  always_ff @(posedge clk) begin
    if (srst) begin
      err_r <= 1'b0;
    end else if (errSet) begin
      err_r <= 1'b1; // [R17]
    end else if (ctrlWr && regWdata[CTRL_CLR_ERR]) begin
      err_r <= 1'b0;
    end
  end

  // security register: zero until loaded, then tracks newly blown bits at once,
  // so a freshly set lock protects the rest of this session too
  always_ff @(posedge clk) begin
    if (srst) begin
      secReg_r <= SEC_RESET;
    end else if (secLoad) begin
      secReg_r <= secWord; // [R2]
    end else if (arrSecWr_r) begin
      secReg_r <= secReg_r | opData_r; // [R18]
    end
  end

  // access gating; nothing is granted until the security word is in place
  // grants follow the live register, so a lock blown mid-session shuts its path at once
  always_ff @(posedge clk) begin
    if (srst) begin
      jtagGrant <= 1'b0;
      linkGrant <= 1'b0;
      jtagOtpGrant <= 1'b0;
    end else begin
      jtagGrant <= bootDone && jtagReq && !secReg_r[SEC_JTAG_OFF]; // [R7]
      linkGrant <= bootDone && linkReq && !secReg_r[SEC_LINK_OFF]; // [R8]
      jtagOtpGrant <= bootDone && jtagOtpReq && !secReg_r[SEC_JTAG_OFF] && !secReg_r[SEC_JTAG_OTP]; // [R13]
    end
  end

  // boot configuration handed to the processor
  // the user code stays zero until the stored word has been loaded
  always_ff @(posedge clk) begin
    if (srst) begin
      cpuRun <= 1'b0;
      bootRomBypass <= 1'b0;
      redundantEn <= 1'b0;
      userIdCode <= '0;
    end else begin
      cpuRun <= bootDone; // [R3]
      bootRomBypass <= secReg_r[SEC_BOOT_OTP]; // [R9]
      redundantEn <= secReg_r[SEC_REDUND]; // [R10]
      userIdCode <= secReg_r[SEC_UID_HI:SEC_UID_LO]; // [R15] [R16]
    end
  end

  // status word behind a control port read
  // busy also covers the boot copy, so software polls a single bit for both
  always_comb begin
    status = '0;
    status[ST_DONE] = bootDone;
    status[ST_BUSY] = (cmdState_r != C_IDLE) || !bootDone;
    status[ST_ERR] = err_r;
    status[ST_RDV] = rdValid_r;
  end

  // read data stand for the one cycle after the strobe; unmapped reads give zero
  // zero outside the slot keeps a shared read bus free of stale words
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        SEC_OFS: regRdata <= secReg_r; // [R14]
        ADDR_PORT_OFS: regRdata <= WORD_W'(addrPort_r);
        DATA_PORT_OFS: regRdata <= rdWord_r;
        CTRL_PORT_OFS: regRdata <= status;
        default: regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

endmodule

/* File: verification/otp_security_config_asserts.sv */
// concurrent checks on the OTP controller top ports
// assumes one clock domain and a synchronous active-high reset
module otp_security_config_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register bus
  input wire logic regRd,
  input wire logic [otp_pkg::WORD_W-1:0] regRdata,
  // access gating
  input wire logic jtagReq,
  input wire logic linkReq,
  input wire logic jtagOtpReq,
  input wire logic jtagGrant,
  input wire logic linkGrant,
  input wire logic jtagOtpGrant,
  // boot outputs
  input wire logic cpuRun,
  input wire logic [otp_pkg::UID_W-1:0] userIdCode,
  input wire logic sramWr,
  input wire logic [otp_pkg::SRAM_AW-1:0] sramAddr
);
  import otp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // two back-to-back copy beats
  sequence s_copy_step;
    sramWr ##1 sramWr;
  endsequence

  a_jtag_gate: assert property (jtagGrant |-> $past(jtagReq)) else $error("jtag grant without request");
  a_link_gate: assert property (linkGrant |-> $past(linkReq)) else $error("link grant without request");
  a_otp_gate: assert property (jtagOtpGrant |-> $past(jtagOtpReq)) else $error("otp grant without request");
  // nothing may reach the tile while the copy still runs
  a_copy_quiet: assert property (sramWr |-> !cpuRun && !jtagGrant && !linkGrant && !jtagOtpGrant)
    else $error("activity during copy");
  a_copy_step: assert property (s_copy_step |-> sramAddr == $past(sramAddr) + 1'b1)
    else $error("copy address skipped");
  a_copy_start: assert property ($rose(sramWr) |-> sramAddr == '0) else $error("copy not from row zero");
  a_run_after: assert property ($fell(sramWr) |-> ##[0:3] cpuRun) else $error("processor not started");
  a_rd_stands: assert property (regRdata != '0 |-> $past(regRd)) else $error("read data outside slot");
  a_reset_quiet: assert property ($fell(srst) |-> !cpuRun && !sramWr && userIdCode == '0 && !jtagGrant)
    else $error("outputs busy after reset");
  a_run_hold: assert property (cpuRun |=> cpuRun) else $error("run dropped");
endmodule

bind otp_security_config otp_security_config_asserts chkI (.clk(clk), .srst(srst), .regRd(regRd),
  .regRdata(regRdata), .jtagReq(jtagReq), .linkReq(linkReq), .jtagOtpReq(jtagOtpReq), .jtagGrant(jtagGrant),
  .linkGrant(linkGrant), .jtagOtpGrant(jtagOtpGrant), .cpuRun(cpuRun), .userIdCode(userIdCode),
  .sramWr(sramWr), .sramAddr(sramAddr));

/* File: verification/sram_model.sv */
// tile SRAM that receives the power-up copy
// assumes writes arrive on clk, one word a pulse
module sram_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // write port
  input wire logic sramWr,
  input wire logic [otp_pkg::SRAM_AW-1:0] sramAddr,
  input wire logic [otp_pkg::WORD_W-1:0] sramWdata
);
  import otp_pkg::*;
  logic [WORD_W-1:0] mem [0:MAIN_ROWS-1];
  int nWr = 0;

  // store copied words; count restarts each power-up so the bench sees one copy
  always_ff @(posedge clk) begin
    if (srst) begin
      nWr <= 0;
    end else if (sramWr) begin
      mem[sramAddr] <= sramWdata;
      nWr <= nWr + 1;
    end
  end
endmodule

/* File: verification/test_otp_security_config.sv */
// self-checking bench for the OTP controller and security word
// assumes the design reaches its ports at the resource ids of the package
module test_otp_security_config;
  timeunit 1ns;
  timeprecision 1ps;
  import otp_pkg::*;
  logic clk = 0, srst = 1, regWr = 0, regRd = 0, jtagReq = 0, linkReq = 0, jtagOtpReq = 0;
  logic [REG_AW-1:0] regAddr = '0;
  logic [WORD_W-1:0] regWdata = '0, regRdata, sramWdata;
  logic jtagGrant, linkGrant, jtagOtpGrant, cpuRun, bootRomBypass, redundantEn, sramWr;
  logic [UID_W-1:0] userIdCode;
  logic [SRAM_AW-1:0] sramAddr;
  int miscompares = 0, n_checks = 0, cyc = 0;
  logic [31:0] seed = 32'h4352, v, st, sec, d1, d2, exp0, exp1;
  logic [15:0] row, row0, row1;

  otp_security_config DUT (.clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .jtagReq(jtagReq), .linkReq(linkReq), .jtagOtpReq(jtagOtpReq),
    .jtagGrant(jtagGrant), .linkGrant(linkGrant), .jtagOtpGrant(jtagOtpGrant), .cpuRun(cpuRun),
    .bootRomBypass(bootRomBypass), .redundantEn(redundantEn), .userIdCode(userIdCode), .sramWr(sramWr),
    .sramAddr(sramAddr), .sramWdata(sramWdata));
  sram_model ram (.clk(clk), .srst(srst), .sramWr(sramWr), .sramAddr(sramAddr), .sramWdata(sramWdata));

  initial forever #2.5 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(logic [23:0] a, logic [31:0] x);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= x;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(logic [23:0] a, output logic [31:0] x);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 x = regRdata;
  endtask

  // one command: ports first, then control, poll busy, then clear the sticky error
  task automatic op(logic [15:0] r, logic [31:0] x, logic [31:0] c, output logic [31:0] s);
    wr(ADDR_PORT_OFS, {16'h0000, r});
    wr(DATA_PORT_OFS, x);
    wr(CTRL_PORT_OFS, c);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 300; i++) begin
      rd(CTRL_PORT_OFS, s);
      if (!s[ST_BUSY]) break;
    end
    wr(CTRL_PORT_OFS, 32'h00008000);
  endtask

  task automatic boot();
    @(posedge clk);
    srst <= 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 3000 && cpuRun !== 1'b1; i++) @(posedge clk);
    for (int i = 0; i < 20; i++) begin
      rd(CTRL_PORT_OFS, v);
      if (v[ST_DONE]) break;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // guard against a hang in any wait
  always @(posedge clk) begin
    cyc++;
    if (cyc > 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    boot();
    rd(SEC_OFS, v);
    chk("sec erased", v, 32'h00000000);
    chk("cpu run", cpuRun, 32'h00000001);
    chk("user id", userIdCode, 32'h00000000);
    chk("copy count", ram.nWr, 32'h00000800);
    jtagReq <= 1'b1;
    linkReq <= 1'b1;
    jtagOtpReq <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("grants open", {jtagGrant, linkGrant, jtagOtpGrant}, 32'h00000007);
    // one row per sector, edge rows among the random ones; two passes OR together
    for (int k = 0; k < 4; k++) begin
      row = 16'(k * SECTOR_ROWS) + (k[0] ? 16'h01FF : 16'(rnd() % SECTOR_ROWS));
      d1 = rnd();
      d2 = rnd();
      op(row, d1, CMD_PROG, st);
      chk("prog err", st[ST_ERR], 32'h00000000);
      op(row, d2, CMD_PROG, st);
      op(row, 32'h00000000, CMD_READ, st);
      rd(DATA_PORT_OFS, v);
      chk("prog or", v, d1 | d2);
      chk("read valid", st[ST_RDV], 32'h00000001);
      if (k == 0) {row0, exp0} = {row, d1 | d2};
      if (k == 1) {row1, exp1} = {row, d1 | d2};
    end
    op(16'h0800, 32'h00000001, CMD_PROG, st);
    chk("spare shut", st[ST_ERR], 32'h00000001);
    op(16'h0803, 32'h00000000, CMD_READ, st);
    chk("oob err", st[ST_ERR], 32'h00000001);
    chk("oob valid", st[ST_RDV], 32'h00000000);
    rd(DATA_PORT_OFS, v);
    chk("oob data", v, 32'h00000000);
    // shut the otp path alone, then the link, so each bit is seen on its own grant
    op(16'h0000, 32'h00002000, CMD_PROG_SEC, st);
    #1;
    chk("otp shut", {jtagGrant, linkGrant, jtagOtpGrant}, 32'h00000006);
    op(16'h0000, 32'h00002002, CMD_PROG_SEC, st);
    #1;
    chk("link shut", {jtagGrant, linkGrant, jtagOtpGrant}, 32'h00000004);
    // security word: both access locks, secure boot, spares, lock on sector one, otp-jtag off
    sec = (rnd() & 32'hFFFF8000) | 32'h000022A3;
    op(16'h0000, sec, CMD_PROG_SEC, st);
    chk("sec prog err", st[ST_ERR], 32'h00000000);
    rd(SEC_OFS, v);
    chk("sec word", v, sec);
    chk("user id", userIdCode, sec[31:22]);
    chk("boot bypass", bootRomBypass, 32'h00000001);
    chk("spare on", redundantEn, 32'h00000001);
    repeat (3) @(posedge clk);
    #1;
    chk("grants shut", {jtagGrant, linkGrant, jtagOtpGrant}, 32'h00000000);
    op(row1, rnd(), CMD_PROG, st);
    chk("lock err", st[ST_ERR], 32'h00000001);
    op(row1, 32'h00000000, CMD_READ, st);
    rd(DATA_PORT_OFS, v);
    chk("locked row", v, exp1);
    d2 = rnd();
    op(16'h0802, d2, CMD_PROG, st);
    op(16'h0802, 32'h00000000, CMD_READ, st);
    rd(DATA_PORT_OFS, v);
    chk("spare row", v, d2);
    op(16'h0000, 32'h00001000, CMD_PROG_SEC, st);
    op(row0, rnd(), CMD_PROG, st);
    chk("master err", st[ST_ERR], 32'h00000001);
    op(16'h0000, 32'h00000004, CMD_PROG_SEC, st);
    chk("master sec", st[ST_ERR], 32'h00000001);
    rd(SEC_OFS, v);
    chk("sec kept", v, sec | 32'h00001000);
    rd(24'h000004, v);
    chk("unmapped", v, 32'h00000000);
    // power up again: stored word and programmed rows come back
    boot();
    rd(SEC_OFS, v);
    chk("sec reload", v, sec | 32'h00001000);
    chk("cpu run again", cpuRun, 32'h00000001);
    chk("sram row", ram.mem[row0[10:0]], exp0);
    chk("copy count", ram.nWr, 32'h00000800);
    tally_and_finish();
  end
endmodule
